// ### common/hot_swap_consts.svh
`ifndef HOT_SWAP_CONSTS_SVH
`define HOT_SWAP_CONSTS_SVH

// ==========================================
// Clock and durations in their own units
`define CLK_PERIOD_NS 100
`define T_POR_NS 25000
`define T_SUPPLY_FILT_NS 5000
`define T_RAIL_FILT_NS 1000
`define T_CLEAR_LOW_NS 1000
`define T_DEBOUNCE_MS 48
`define T_CB_INT_US 500
`define T_COOL_MS 900

// ==========================================
// Derived counts, least times rounded up
`define CYC_CEIL(t_ns) (((t_ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NS_PER_US 1000
`define NS_PER_MS 1000000

// ==========================================
// Structure
`define TIMER_CYCLES 8
`define CNT_W 24
`define FILT_W 8
`define CYC_W 3

`endif

// ### common/hot_swap_pkg.sv
package hot_swap_pkg;

    // ==========================================
    // Sequencer states
    typedef enum logic [4:0] {
        S_LOCKOUT  = 5'h01,
        S_POR      = 5'h02,
        S_DEBOUNCE = 5'h04,
        S_ON       = 5'h08,
        S_COOL     = 5'h10
    } seq_state_t;

endpackage

// ### verilog/persist_filter.sv
`include "hot_swap_consts.svh"

module persist_filter #(
    parameter int unsigned COUNT = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic level,
    output logic hit
);

    logic [`FILT_W-1:0] cnt_q;
    logic [`FILT_W-1:0] cnt_d;
    logic hit_q;
    logic hit_d;

    // ==========================================
    // Consecutive-sample counter, saturating
    always_comb begin
        if (!level) begin
            cnt_d = '0;
        end else if (cnt_q == `FILT_W'(COUNT)) begin
            cnt_d = cnt_q;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
        hit_d = level && (cnt_q >= `FILT_W'(COUNT - 1));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            hit_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            hit_q <= hit_d;
        end
    end

    assign hit = hit_q;

endmodule // persist_filter

// ### verilog/hot_swap_sequence_fault_control.sv
`include "hot_swap_consts.svh"

module hot_swap_sequence_fault_control #(
    parameter int unsigned DEBOUNCE_CYCLES =
        (`T_DEBOUNCE_MS * `NS_PER_MS) / `CLK_PERIOD_NS,
    parameter int unsigned CB_CYCLES =
        `CYC_CEIL(`T_CB_INT_US * `NS_PER_US),
    parameter int unsigned COOL_CYCLES =
        (`T_COOL_MS * `NS_PER_MS) / `CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic supply_ok_in,
    input wire logic rail_ok_in,
    input wire logic rail_low_in,
    input wire logic supply_low_enable_in,
    input wire logic enable_clear_in,
    input wire logic input_high_limit_in,
    input wire logic output_feedback_in,
    input wire logic gate_drive_ok_in,
    input wire logic current_limit_in,
    input wire logic timer_high_in,
    input wire logic timer_low_in,
    input wire logic timer_strap_in,
    input wire logic temp_hot_in,
    input wire logic temp_cool_in,
    output logic gate_on_out,
    output logic slow_pulldown_out,
    output logic fast_pulldown_out,
    output logic timer_charge_out,
    output logic timer_discharge_out,
    output logic power_good_n_out,
    output logic power_good_oe,
    output logic fault_out_n,
    output logic fault_oe
);
    import hot_swap_pkg::*;

    localparam int unsigned POR_CYCLES = `CYC_CEIL(`T_POR_NS);
    localparam int unsigned SUP_FILT = `CYC_CEIL(`T_SUPPLY_FILT_NS);
    localparam int unsigned RAIL_FILT = `CYC_CEIL(`T_RAIL_FILT_NS);
    localparam int unsigned CLR_FILT = `CYC_CEIL(`T_CLEAR_LOW_NS);

    function automatic logic at_end(input logic [`CNT_W-1:0] c, input int unsigned n);
        return c == `CNT_W'(n - 1);
    endfunction

    // ==========================================
    // Input synchronizers
    logic [13:0] s1_q;
    logic [13:0] s2_q;
    logic sup_s, rok_s, rlow_s, en_s, en_clr_s, hilim_s, fbk_s, gd_s;
    logic cl_s, th_s, tl_s, ext_n_s, hot_s, cool_s;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= {supply_ok_in, rail_ok_in, rail_low_in, supply_low_enable_in,
                     enable_clear_in, input_high_limit_in, output_feedback_in,
                     gate_drive_ok_in, current_limit_in, timer_high_in, timer_low_in,
                     timer_strap_in, temp_hot_in, temp_cool_in};
            s2_q <= s1_q;
        end
    end

    assign {sup_s, rok_s, rlow_s, en_s, en_clr_s, hilim_s, fbk_s, gd_s,
            cl_s, th_s, tl_s, ext_n_s, hot_s, cool_s} = s2_q;

    // ==========================================
    // Persistence filters
    logic sup_low_hit, rail_low_hit, clr_hit;
    logic fast_evt;

    persist_filter #(.COUNT(SUP_FILT)) u_sup_filt (
        .clk(clk),
        .rst_n(rst_n),
        .level(!sup_s),
        .hit(sup_low_hit)
    );

    persist_filter #(.COUNT(RAIL_FILT)) u_rail_filt (
        .clk(clk),
        .rst_n(rst_n),
        .level(rlow_s),
        .hit(rail_low_hit)
    );

    persist_filter #(.COUNT(CLR_FILT)) u_clr_filt (
        .clk(clk),
        .rst_n(rst_n),
        .level(!en_clr_s),
        .hit(clr_hit)
    );

    assign fast_evt = sup_low_hit || rail_low_hit;

    // ==========================================
    // Sequencer state
    seq_state_t state_q, state_d;
    logic [`CNT_W-1:0] cnt_q, cnt_d;
    logic [`CYC_W-1:0] cyc_q, cyc_d;
    logic phase_q, phase_d;
    logic fault_q, fault_d;
    logic hot_q, hot_d;
    logic gate_q, gate_d;
    logic slow_q, slow_d;
    logic fast_q, fast_d;
    logic chg_q, chg_d;
    logic dis_q, dis_d;
    logic good_oe_q, good_oe_d;
    logic trip;
    logic inputs_ok;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        cyc_d = cyc_q;
        phase_d = phase_q;
        fault_d = fault_q;
        hot_d = hot_q;
        trip = 1'b0;
        inputs_ok = sup_s && rok_s && en_s && !hilim_s;
        if (hot_s) begin
            hot_d = 1'b1;
        end else if (cool_s) begin
            hot_d = 1'b0;
        end
        if (clr_hit) begin
            fault_d = 1'b0;
        end
        case (state_q)
            S_LOCKOUT: begin
                cnt_d = '0;
                if (sup_s && rok_s) begin
                    state_d = S_POR;
                end
            end
            S_POR: begin
                fault_d = 1'b0;
                hot_d = 1'b0;
                cyc_d = '0;
                phase_d = 1'b0;
                cnt_d = cnt_q + 1'b1;
                if (at_end(cnt_q, POR_CYCLES)) begin
                    state_d = S_DEBOUNCE;
                    cnt_d = '0;
                end
            end
            S_DEBOUNCE: begin
                if (inputs_ok && !fault_q) begin
                    cnt_d = cnt_q + 1'b1;
                    if (at_end(cnt_q, DEBOUNCE_CYCLES)) begin
                        state_d = S_ON;
                        cnt_d = '0;
                    end
                end else begin
                    cnt_d = '0;
                end
            end
            S_ON: begin
                if (!en_s) begin
                    state_d = S_DEBOUNCE;
                    cnt_d = '0;
                end else if (cl_s) begin
                    cnt_d = cnt_q + 1'b1;
                    trip = ext_n_s ? at_end(cnt_q, CB_CYCLES) : th_s;
                end else begin
                    cnt_d = '0;
                end
                if (trip) begin
                    fault_d = 1'b1;
                    state_d = S_COOL;
                    cnt_d = '0;
                    cyc_d = '0;
                    phase_d = 1'b0;
                end
            end
            S_COOL: begin
                if (ext_n_s) begin
                    cnt_d = cnt_q + 1'b1;
                    if (at_end(cnt_q, COOL_CYCLES)) begin
                        state_d = S_DEBOUNCE;
                        cnt_d = '0;
                    end
                end else if (!phase_q) begin
                    if (tl_s) begin
                        cyc_d = cyc_q + 1'b1;
                        phase_d = 1'b1;
                        if (cyc_q == `CYC_W'(`TIMER_CYCLES - 1)) begin
                            state_d = S_DEBOUNCE;
                            phase_d = 1'b0;
                        end
                    end
                end else if (th_s) begin
                    phase_d = 1'b0;
                end
            end
            default: begin
                state_d = S_LOCKOUT;
            end
        endcase
        if (fast_evt) begin
            state_d = S_LOCKOUT;
            cnt_d = '0;
        end
    end

    // ==========================================
    // Output drive
    always_comb begin
        gate_d = (state_q == S_ON) && en_s && !hilim_s && !hot_q && !trip
                 && !fast_evt;
        fast_d = fast_evt || (state_d == S_LOCKOUT);
        slow_d = !gate_d && !fast_d;
        chg_d = !ext_n_s && (((state_d == S_ON) && cl_s && en_s)
                || ((state_d == S_COOL) && phase_d));
        dis_d = !ext_n_s && !chg_d;
        good_oe_d = !(gate_d && fbk_s && gd_s);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_LOCKOUT;
            cnt_q <= '0;
            cyc_q <= '0;
            phase_q <= 1'b0;
            fault_q <= 1'b0;
            hot_q <= 1'b0;
            gate_q <= 1'b0;
            slow_q <= 1'b0;
            fast_q <= 1'b1;
            chg_q <= 1'b0;
            dis_q <= 1'b0;
            good_oe_q <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            cyc_q <= cyc_d;
            phase_q <= phase_d;
            fault_q <= fault_d;
            hot_q <= hot_d;
            gate_q <= gate_d;
            slow_q <= slow_d;
            fast_q <= fast_d;
            chg_q <= chg_d;
            dis_q <= dis_d;
            good_oe_q <= good_oe_d;
        end
    end

    assign gate_on_out = gate_q;
    assign slow_pulldown_out = slow_q;
    assign fast_pulldown_out = fast_q;
    assign timer_charge_out = chg_q;
    assign timer_discharge_out = dis_q;
    assign power_good_n_out = 1'b0;
    assign power_good_oe = good_oe_q;
    assign fault_out_n = 1'b0;
    assign fault_oe = fault_q;

    // ==========================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_por_end_clears:
    assert property ((state_q == S_POR) && at_end(cnt_q, POR_CYCLES) && !fast_evt
        |=> (state_q == S_DEBOUNCE) && !fault_oe)
        else $error("reset pulse end not followed by cleared debounce");

    a_on_after_deb:
    assert property ((state_q == S_ON) && !$past(state_q == S_ON)
        |-> $past(at_end(cnt_q, DEBOUNCE_CYCLES)) && $past(inputs_ok))
        else $error("turn-on without full debounce");

    a_good_release:
    assert property (!power_good_oe |-> $past(fbk_s) && $past(gd_s) && gate_on_out)
        else $error("power good released without feedback and gate drive");

    a_enable_turnoff:
    assert property ((state_q == S_ON) && !en_s |=> !gate_on_out ##1 !gate_on_out)
        else $error("enable low did not turn the switch off");

    a_fault_off:
    assert property ((state_q == S_ON) && (hilim_s || hot_q) |=> !gate_on_out)
        else $error("fault did not turn the switch off");

    a_slow_select:
    assert property ($fell(gate_on_out) && !fast_pulldown_out |-> slow_pulldown_out)
        else $error("normal turn-off not using slow pulldown");

    a_good_low_off:
    assert property (!gate_on_out || !$past(fbk_s) |-> power_good_oe)
        else $error("power good not low with switch off");

    a_fast_shutdown:
    assert property (fast_evt |=> fast_pulldown_out && !gate_on_out && !slow_pulldown_out)
        else $error("fast shutdown not driving strong pulldown");

    a_cb_internal:
    assert property ((state_q == S_ON) ##1 (state_q == S_COOL) && $past(ext_n_s)
        |-> $past(at_end(cnt_q, CB_CYCLES)) && fault_oe)
        else $error("internal breaker tripped at wrong count");

    a_cool_exit:
    assert property ((state_q == S_COOL) ##1 (state_q == S_DEBOUNCE)
        |-> $past(ext_n_s) ? $past(at_end(cnt_q, COOL_CYCLES))
                           : $past(cyc_q) == `CYC_W'(`TIMER_CYCLES - 1))
        else $error("cool-down ended early");

    a_limit_resume:
    assert property ((state_q == S_ON) && hilim_s ##1 (state_q == S_ON) && !hilim_s && en_s
        && !hot_q && !cl_s && !fast_evt |=> gate_on_out)
        else $error("gate did not resume after overvoltage");

endmodule // hot_swap_sequence_fault_control

// ### bench/power_path_model.sv
module power_path_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic gate_on_out,
    input wire logic timer_charge_out,
    input wire logic timer_discharge_out,
    output logic output_feedback_in,
    output logic gate_drive_ok_in,
    output logic timer_high_in,
    output logic timer_low_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // Output node and timer capacitor levels
    localparam int OUT_TOP = 8;
    localparam int TMR_TOP = 24;
    int out_lvl;
    int tmr_lvl;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_lvl <= 0;
            tmr_lvl <= 0;
        end else begin
            if (gate_on_out && out_lvl < OUT_TOP) begin
                out_lvl <= out_lvl + 1;
            end else if (!gate_on_out && out_lvl > 0) begin
                out_lvl <= out_lvl - 1;
            end
            if (timer_charge_out && tmr_lvl < TMR_TOP) begin
                tmr_lvl <= tmr_lvl + 4;
            end else if (timer_discharge_out && tmr_lvl > 0) begin
                tmr_lvl <= tmr_lvl - 1;
            end
        end
    end
    assign output_feedback_in = (out_lvl >= 5);
    assign gate_drive_ok_in = (out_lvl == OUT_TOP);
    assign timer_high_in = (tmr_lvl >= TMR_TOP);
    assign timer_low_in = (tmr_lvl == 0);
endmodule // power_path_model

// ### bench/tb_hot_swap_sequence_fault_control.sv
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
    $display("BAD %0t mismatch at line %0d", $time, `__LINE__); end end

module tb_hot_swap_sequence_fault_control;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DEB = 100;
    localparam int CB = 20;
    localparam int COOL = 50;
    localparam int TMR_DN = 24;
    typedef struct packed {
        logic en;
        logic hi;
        logic hot;
        logic cool;
        logic [7:0] wait_n;
        logic gate;
        logic slow;
        logic pgoe;
    } row_t;
    row_t rows [8] = '{
        '{1'b1, 1'b1, 1'b0, 1'b1, 8'h14, 1'b0, 1'b1, 1'b1},
        '{1'b1, 1'b0, 1'b0, 1'b1, 8'h1e, 1'b1, 1'b0, 1'b0},
        '{1'b1, 1'b0, 1'b1, 1'b0, 8'h14, 1'b0, 1'b1, 1'b1},
        '{1'b1, 1'b0, 1'b0, 1'b0, 8'h14, 1'b0, 1'b1, 1'b1},
        '{1'b1, 1'b0, 1'b0, 1'b1, 8'h1e, 1'b1, 1'b0, 1'b0},
        '{1'b0, 1'b0, 1'b0, 1'b1, 8'h14, 1'b0, 1'b1, 1'b1},
        '{1'b1, 1'b0, 1'b0, 1'b1, 8'h1e, 1'b0, 1'b1, 1'b1},
        '{1'b1, 1'b0, 1'b0, 1'b1, 8'h78, 1'b1, 1'b0, 1'b0}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic supply_ok_in = 1'b0, rail_ok_in = 1'b0, rail_low_in = 1'b0;
    logic en_q = 1'b0, clr_q = 1'b1, loopback = 1'b0;
    logic input_high_limit_in = 1'b0, current_limit_in = 1'b0;
    logic timer_strap_in = 1'b1, temp_hot_in = 1'b0, temp_cool_in = 1'b1;
    logic supply_low_enable_in, enable_clear_in;
    logic output_feedback_in, gate_drive_ok_in, timer_high_in, timer_low_in;
    logic gate_on_out, slow_pulldown_out, fast_pulldown_out, timer_charge_out;
    logic timer_discharge_out, power_good_n_out, power_good_oe, fault_out_n, fault_oe;
    int n_fail = 0;
    int comparisons = 0;
    int i;
    int t;

    always #50 clk = ~clk;
    // Fault pin wired back to the enable and clear pins when looped
    assign supply_low_enable_in = loopback ? !fault_oe : en_q;
    assign enable_clear_in = loopback ? !fault_oe : clr_q;

    hot_swap_sequence_fault_control #(.DEBOUNCE_CYCLES(DEB), .CB_CYCLES(CB),
        .COOL_CYCLES(COOL)) dut_u (.clk(clk), .rst_n(rst_n), .supply_ok_in(supply_ok_in),
        .rail_ok_in(rail_ok_in), .rail_low_in(rail_low_in),
        .supply_low_enable_in(supply_low_enable_in), .enable_clear_in(enable_clear_in),
        .input_high_limit_in(input_high_limit_in), .output_feedback_in(output_feedback_in),
        .gate_drive_ok_in(gate_drive_ok_in), .current_limit_in(current_limit_in),
        .timer_high_in(timer_high_in), .timer_low_in(timer_low_in),
        .timer_strap_in(timer_strap_in), .temp_hot_in(temp_hot_in),
        .temp_cool_in(temp_cool_in), .gate_on_out(gate_on_out),
        .slow_pulldown_out(slow_pulldown_out), .fast_pulldown_out(fast_pulldown_out),
        .timer_charge_out(timer_charge_out), .timer_discharge_out(timer_discharge_out),
        .power_good_n_out(power_good_n_out), .power_good_oe(power_good_oe),
        .fault_out_n(fault_out_n), .fault_oe(fault_oe));

    power_path_model path_u (.clk(clk), .rst_n(rst_n), .gate_on_out(gate_on_out),
        .timer_charge_out(timer_charge_out), .timer_discharge_out(timer_discharge_out),
        .output_feedback_in(output_feedback_in), .gate_drive_ok_in(gate_drive_ok_in),
        .timer_high_in(timer_high_in), .timer_low_in(timer_low_in));

    // ==========================================
    // Helpers
    task automatic stop_test();
        $display("Comparisons %0d, failures %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wait_gate(input logic v, input int lim, output int k);
        k = 0;
        while (gate_on_out !== v && k < lim) begin
            @(negedge clk);
            k++;
        end
        if (gate_on_out !== v) begin
            n_fail++;
            $display("BAD %0t gate wait ran out", $time);
            stop_test();
        end
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("BAD %0t run too long", $time);
        stop_test();
    end

    // ==========================================
    // Main sequence
    initial begin
        cyc(7);
        `CHECK({gate_on_out, fast_pulldown_out, power_good_oe, fault_oe}, 4'h6)
        `CHECK(fault_out_n, 1'b0)
        `CHECK(power_good_n_out, 1'b0)
        @(posedge clk);
        rst_n <= 1'b1;
        supply_ok_in <= 1'b1;
        rail_ok_in <= 1'b1;
        en_q <= 1'b1;
        wait_gate(1'b1, 600, t);
        `CHECK(t >= 250 + DEB, 1'b1)
        cyc(20);
        `CHECK({slow_pulldown_out, fast_pulldown_out, power_good_oe}, 3'h0)
        for (i = 0; i < 8; i++) begin
            @(posedge clk);
            en_q <= rows[i].en;
            input_high_limit_in <= rows[i].hi;
            temp_hot_in <= rows[i].hot;
            temp_cool_in <= rows[i].cool;
            cyc(int'(rows[i].wait_n));
            `CHECK(gate_on_out, rows[i].gate)
            `CHECK(slow_pulldown_out, rows[i].slow)
            `CHECK(power_good_oe, rows[i].pgoe)
        end
        // Internal breaker delay, latched fault
        @(posedge clk);
        current_limit_in <= 1'b1;
        wait_gate(1'b0, 60, t);
        `CHECK(t >= CB, 1'b1)
        cyc(1);
        `CHECK({slow_pulldown_out, fast_pulldown_out, fault_oe}, 3'h5)
        `CHECK({timer_charge_out, timer_discharge_out}, 2'h0)
        @(posedge clk);
        current_limit_in <= 1'b0;
        cyc(COOL + DEB + 100);
        `CHECK(gate_on_out, 1'b0)
        // Auto retry in internal mode
        @(posedge clk);
        loopback <= 1'b1;
        wait_gate(1'b1, 300, t);
        `CHECK(fault_oe, 1'b0)
        @(posedge clk);
        current_limit_in <= 1'b1;
        wait_gate(1'b0, 60, t);
        @(posedge clk);
        current_limit_in <= 1'b0;
        wait_gate(1'b1, 400, t);
        `CHECK(t >= COOL + DEB, 1'b1)
        // External timer, manual clear
        @(posedge clk);
        loopback <= 1'b0;
        timer_strap_in <= 1'b0;
        current_limit_in <= 1'b1;
        cyc(5);
        `CHECK(timer_charge_out, 1'b1)
        wait_gate(1'b0, 100, t);
        `CHECK(fault_oe, 1'b1)
        `CHECK({timer_charge_out, timer_discharge_out}, 2'h1)
        @(posedge clk);
        current_limit_in <= 1'b0;
        en_q <= 1'b0;
        clr_q <= 1'b0;
        cyc(15);
        @(posedge clk);
        en_q <= 1'b1;
        clr_q <= 1'b1;
        wait_gate(1'b1, 1000, t);
        `CHECK(t >= 8 * TMR_DN + DEB - 20, 1'b1)
        // Fast shutdown filters
        @(posedge clk);
        timer_strap_in <= 1'b1;
        supply_ok_in <= 1'b0;
        cyc(30);
        @(posedge clk);
        supply_ok_in <= 1'b1;
        cyc(10);
        `CHECK(gate_on_out, 1'b1)
        @(posedge clk);
        supply_ok_in <= 1'b0;
        cyc(60);
        `CHECK({gate_on_out, fast_pulldown_out}, 2'h1)
        @(posedge clk);
        supply_ok_in <= 1'b1;
        wait_gate(1'b1, 600, t);
        `CHECK(t >= 250 + DEB, 1'b1)
        @(posedge clk);
        rail_low_in <= 1'b1;
        cyc(20);
        `CHECK({gate_on_out, fast_pulldown_out}, 2'h1)
        stop_test();
    end
endmodule // tb_hot_swap_sequence_fault_control
